// File: core/mdc_io_control.sv
// motor drive io control: operation input decode and status outputs
//
// Summary of operation
// - two-wire: run while only one of forward or reverse input on, stop on release
// - two-wire: direction follows rotation setting for the active input
// - two-wire: stop-style input picks deceleration or instantaneous stop
// - four select inputs pick up to 16 data; two inputs limit to 4
// - alarm-clear input clears the active alarm after a trip
// - brake-release at standstill frees the brake on brake motors
// - three-wire: run only while run-gate and hard-run-enable both on
// - three-wire: releasing run-gate decelerates to a stop
// - three-wire: releasing hard-run-enable stops instantly
// - three-wire: direction-select sets the rotation direction
// - hold-release decides whether a stopped shaft is held
// - normally closed torque-limit-enable switches torque limiting
// - notice-clear clears the present notice status
// - normally closed panel-unlock governs panel restriction
// - normally closed external fault: released raises alarm, stops
// - rotation pulse output gives 30 pulses per output shaft turn
// - fault output, normally closed, changes when protection trips
// - motion output on while rotating under an operation input
// - notice output on while a notice condition stands
// - torque-limited output on when torque reaches the limit
// - speed-reached on when speed within set speed plus or minus width
// - rotation-sense output reports the present rotation direction
// - a setting picks two-wire or three-wire input mode
// - data number is binary of select inputs, bit0 lowest
// - alarm clears on rising clear edge, ignored while run inputs on
// - direction-select on turns counterclockwise, off clockwise
`timescale 1ns/1ps
module mdc_io_control (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic three_wire_mode_in,
   input wire logic forward_is_ccw_in,
   input wire logic forward_run_in,
   input wire logic reverse_run_in,
   input wire logic stop_mode_in,
   input wire logic run_gate_in,
   input wire logic hard_run_enable_in,
   input wire logic direction_select_in,
   input wire logic speed_select_bit0_in,
   input wire logic speed_select_bit1_in,
   input wire logic speed_select_bit2_in,
   input wire logic speed_select_bit3_in,
   input wire logic speed_select_wide_in,
   input wire logic alarm_clear_in,
   input wire logic protect_trip_in,
   input wire logic external_fault_stop_in,
   input wire logic brake_motor_in,
   input wire logic brake_release_in,
   input wire logic hold_enable_in,
   input wire logic hold_release_in,
   input wire logic torque_limit_enable_in,
   input wire logic torque_at_limit_in,
   input wire logic notice_event_in,
   input wire logic notice_clear_in,
   input wire logic panel_unlock_in,
   input wire logic motor_rotating_in,
   input wire logic rotor_step_in,
   input wire logic rotor_step_ccw_in,
   input wire logic [mdc_pkg::SPEED_W-1:0] speed_set_in,
   input wire logic [mdc_pkg::SPEED_W-1:0] speed_detect_in,
   input wire logic [mdc_pkg::SPEED_W-1:0] speed_window_in,
   output logic run_cmd_out,
   output logic decel_stop_out,
   output logic instant_stop_out,
   output logic dir_ccw_cmd_out,
   output logic [mdc_pkg::SEL_W-1:0] op_data_number_out,
   output logic brake_release_out,
   output logic shaft_hold_out,
   output logic torque_limit_active_out,
   output logic panel_locked_out,
   output logic alarm_active_out,
   output logic fault_n_out,
   output logic speed_pulse_out,
   output logic motion_active_out,
   output logic notice_out,
   output logic torque_limited_flag_out,
   output logic speed_reached_out,
   output logic rotation_ccw_out
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      mdc_pkg::mdc_motion_type motion;
      logic dir_ccw;
      logic [mdc_pkg::SEL_W-1:0] op_data;
      logic brake_rel;
      logic hold;
      logic trq_lim_on;
      logic panel_locked;
      logic torque_lim;
      logic reached;
      logic rot_ccw;
      logic moving;
   } mdc_main_type;

   mdc_main_type st_reg;
   mdc_main_type st_next;

   mdc_flag_if alarm_if ();
   mdc_flag_if notice_if ();

   logic fault_now;
   logic run_inputs_on;
   logic run_request;
   logic instant_req;
   logic req_dir_ccw;
   logic stopped;
   logic [mdc_pkg::SPEED_W-1:0] speed_diff;

   // ------------------------------------------------------------
   // operation input decode
   // ------------------------------------------------------------
   assign fault_now = alarm_if.flag || !external_fault_stop_in
                      || protect_trip_in;
   always_comb begin
      if (three_wire_mode_in) begin
         run_inputs_on = run_gate_in && hard_run_enable_in;
         instant_req = !hard_run_enable_in;
         req_dir_ccw = direction_select_in;
      end else begin
         // both inputs on counts as a stop request
         run_inputs_on = forward_run_in ^ reverse_run_in;
         instant_req = stop_mode_in;
         req_dir_ccw = forward_run_in ? forward_is_ccw_in
                                      : !forward_is_ccw_in;
      end
   end
   assign run_request = run_inputs_on && !fault_now;
   assign stopped = (st_reg.motion == mdc_pkg::ST_STOPPED)
                    && !motor_rotating_in;
   assign speed_diff = (speed_detect_in >= speed_set_in)
                       ? speed_detect_in - speed_set_in
                       : speed_set_in - speed_detect_in;

   // ------------------------------------------------------------
   // alarm and notice flags
   // ------------------------------------------------------------
   assign alarm_if.set_evt = protect_trip_in || !external_fault_stop_in;
   assign alarm_if.clr_level = alarm_clear_in;
   assign alarm_if.clr_allow = three_wire_mode_in
      ? !(run_gate_in && hard_run_enable_in)
      : !(forward_run_in || reverse_run_in);
   assign notice_if.set_evt = notice_event_in;
   assign notice_if.clr_level = notice_clear_in;
   assign notice_if.clr_allow = 1'b1;

   mdc_sticky_flag u_alarm (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .fl(alarm_if.owner)
   );

   mdc_sticky_flag u_notice (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .fl(notice_if.owner)
   );

   mdc_rot_pulse u_pulse (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .step_in(rotor_step_in),
      .pulse_out(speed_pulse_out)
   );

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      case (st_reg.motion)
         mdc_pkg::ST_STOPPED: begin
            if (run_request) begin
               st_next.motion = mdc_pkg::ST_RUNNING;
            end
         end
         mdc_pkg::ST_RUNNING: begin
            if (fault_now) begin
               st_next.motion = mdc_pkg::ST_HALT;
            end else if (!run_request) begin
               st_next.motion = instant_req ? mdc_pkg::ST_HALT
                                            : mdc_pkg::ST_DECEL;
            end
         end
         mdc_pkg::ST_DECEL: begin
            if (fault_now || instant_req) begin
               st_next.motion = mdc_pkg::ST_HALT;
            end else if (run_request) begin
               st_next.motion = mdc_pkg::ST_RUNNING;
            end else if (!motor_rotating_in) begin
               st_next.motion = mdc_pkg::ST_STOPPED;
            end
         end
         mdc_pkg::ST_HALT: begin
            if (!motor_rotating_in) begin
               st_next.motion = mdc_pkg::ST_STOPPED;
            end
         end
         default: begin
            st_next.motion = mdc_pkg::ST_STOPPED;
         end
      endcase
      if (run_request) begin
         st_next.dir_ccw = req_dir_ccw;
      end
      st_next.op_data = speed_select_wide_in
         ? {speed_select_bit3_in, speed_select_bit2_in,
            speed_select_bit1_in, speed_select_bit0_in}
         : {mdc_pkg::NARROW_SEL_HI, mdc_pkg::NARROW_SEL_HI,
            speed_select_bit1_in, speed_select_bit0_in};
      st_next.brake_rel = brake_motor_in && stopped
                          && brake_release_in && !alarm_if.flag;
      st_next.hold = hold_enable_in && stopped && !hold_release_in
                     && !(brake_motor_in && brake_release_in);
      st_next.trq_lim_on = torque_limit_enable_in;
      st_next.panel_locked = !panel_unlock_in;
      st_next.torque_lim = torque_limit_enable_in
                           && torque_at_limit_in;
      st_next.reached = (speed_diff <= speed_window_in);
      if (rotor_step_in) begin
         st_next.rot_ccw = rotor_step_ccw_in;
      end
      st_next.moving = (st_reg.motion == mdc_pkg::ST_RUNNING)
                       && motor_rotating_in;
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign run_cmd_out = (st_reg.motion == mdc_pkg::ST_RUNNING);
   assign decel_stop_out = (st_reg.motion == mdc_pkg::ST_DECEL);
   assign instant_stop_out = (st_reg.motion == mdc_pkg::ST_HALT);
   assign dir_ccw_cmd_out = st_reg.dir_ccw;
   assign op_data_number_out = st_reg.op_data;
   assign brake_release_out = st_reg.brake_rel;
   assign shaft_hold_out = st_reg.hold;
   assign torque_limit_active_out = st_reg.trq_lim_on;
   assign panel_locked_out = st_reg.panel_locked;
   assign alarm_active_out = alarm_if.flag;
   assign fault_n_out = !alarm_if.flag;
   assign motion_active_out = st_reg.moving;
   assign notice_out = notice_if.flag;
   assign torque_limited_flag_out = st_reg.torque_lim;
   assign speed_reached_out = st_reg.reached;
   assign rotation_ccw_out = st_reg.rot_ccw;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);

   a_run_starts: assert property
      ((run_request && st_reg.motion == mdc_pkg::ST_STOPPED)
       |=> run_cmd_out)
      else $error("run request did not start the motor");
   a_run_gated: assert property
      ((three_wire_mode_in && !(run_gate_in && hard_run_enable_in))
       |=> !run_cmd_out)
      else $error("three-wire run without both inputs");
   a_decel_path: assert property
      ((run_cmd_out && three_wire_mode_in && !run_gate_in
        && hard_run_enable_in && !fault_now) |=> decel_stop_out)
      else $error("run-gate release did not decelerate");
   a_instant_stop: assert property
      ((run_cmd_out && three_wire_mode_in && !hard_run_enable_in)
       |=> instant_stop_out)
      else $error("hard-run-enable release not instant");
   a_stop_style: assert property
      ((run_cmd_out && !three_wire_mode_in && !run_inputs_on
        && !fault_now) |=> (instant_stop_out == $past(stop_mode_in)))
      else $error("stop style input ignored");
   a_dir_three: assert property
      ((run_request && three_wire_mode_in)
       |=> dir_ccw_cmd_out == $past(direction_select_in))
      else $error("three-wire direction wrong");
   a_dir_two: assert property
      ((run_request && !three_wire_mode_in && reverse_run_in)
       |=> dir_ccw_cmd_out == !$past(forward_is_ccw_in))
      else $error("two-wire reverse direction wrong");
   a_data_narrow: assert property
      (!speed_select_wide_in |=> op_data_number_out[3:2] == 2'h0)
      else $error("narrow select gave high data bits");
   a_ext_fault: assert property
      (!external_fault_stop_in |=> alarm_active_out && !run_cmd_out
       ##1 !fault_n_out)
      else $error("external fault did not stop the motor");
   a_clear_block: assert property
      ((alarm_active_out && run_inputs_on && !alarm_if.clr_allow)
       |=> alarm_active_out)
      else $error("alarm cleared while run inputs on");
   a_brake_alarm: assert property
      (brake_release_out |-> $past(!alarm_active_out && !run_cmd_out))
      else $error("brake released while alarmed or running");
   a_reached: assert property
      ((speed_detect_in == speed_set_in) |=> speed_reached_out)
      else $error("speed-reached missing at set speed");

   c_two_wire_run: cover property
      (!three_wire_mode_in && run_cmd_out ##[1:20] decel_stop_out);
   c_three_wire_halt: cover property
      (three_wire_mode_in && run_cmd_out ##1 instant_stop_out);
   c_alarm_cleared: cover property
      (alarm_active_out ##1 !alarm_active_out);
   c_notice_cleared: cover property (notice_out ##1 !notice_out);
endmodule // mdc_io_control

// File: core/mdc_rot_pulse.sv
// rotation pulse generator: fixed pulses per shaft turn, fixed width
`timescale 1ns/1ps
module mdc_rot_pulse (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic step_in,
   output logic pulse_out
);
   typedef struct packed {
      logic [mdc_pkg::STEP_W-1:0] step_cnt;
      logic [mdc_pkg::TIMER_W-1:0] width_cnt;
      logic pulse;
   } mdc_pulse_type;

   mdc_pulse_type st_reg;
   mdc_pulse_type st_next;

   always_comb begin
      st_next = st_reg;
      if (st_reg.width_cnt != mdc_pkg::TIMER_RST) begin
         st_next.width_cnt = st_reg.width_cnt - 1'b1;
      end
      if (step_in) begin
         if (st_reg.step_cnt == mdc_pkg::STEPS_PER_PULSE_M1) begin
            st_next.step_cnt = mdc_pkg::STEP_RST;
            // a pulse still in progress is not restarted
            if (st_reg.width_cnt == mdc_pkg::TIMER_RST) begin
               st_next.width_cnt = mdc_pkg::PULSE_WIDTH_CYC;
            end
         end else begin
            st_next.step_cnt = st_reg.step_cnt + 1'b1;
         end
      end
      st_next.pulse = (st_next.width_cnt != mdc_pkg::TIMER_RST);
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign pulse_out = st_reg.pulse;

   logic [mdc_pkg::TIMER_W-1:0] hi_cnt;
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         hi_cnt <= mdc_pkg::TIMER_RST;
      end else if (st_reg.pulse) begin
         hi_cnt <= hi_cnt + 1'b1;
      end else begin
         hi_cnt <= mdc_pkg::TIMER_RST;
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);

   a_pulse_width: assert property
      ($fell(st_reg.pulse) |-> $past(hi_cnt) ==
       mdc_pkg::PULSE_WIDTH_CYC - 1'b1)
      else $error("rotation pulse width wrong");
   c_pulse_seen: cover property ($rose(st_reg.pulse));
endmodule // mdc_rot_pulse

// File: core/mdc_sticky_flag.sv
// sticky flag set by an event and cleared on a rising clear edge
`timescale 1ns/1ps
module mdc_sticky_flag (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   mdc_flag_if.owner fl
);
   typedef struct packed {
      logic flag;
      logic clr_prev;
   } mdc_sticky_type;

   mdc_sticky_type st_reg;
   mdc_sticky_type st_next;
   logic clr_edge;

   assign clr_edge = fl.clr_level && !st_reg.clr_prev;

   always_comb begin
      st_next = st_reg;
      st_next.clr_prev = fl.clr_level;
      // set wins over a clear in the same cycle
      if (fl.set_evt) begin
         st_next.flag = 1'b1;
      end else if (clr_edge && fl.clr_allow) begin
         st_next.flag = 1'b0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign fl.flag = st_reg.flag;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);

   a_set_wins: assert property (fl.set_evt |=> fl.flag)
      else $error("sticky flag lost a set event");
   a_clear_edge: assert property
      ((clr_edge && fl.clr_allow && !fl.set_evt) |=> !fl.flag)
      else $error("sticky flag not cleared on edge");
endmodule // mdc_sticky_flag

// File: include/mdc_flag_if.sv
// interface carrying a sticky status flag with its set and clear terms
`timescale 1ns/1ps
interface mdc_flag_if;
   logic set_evt;
   logic clr_level;
   logic clr_allow;
   logic flag;
   modport owner (input set_evt, input clr_level, input clr_allow,
                  output flag);
   modport user (output set_evt, output clr_level, output clr_allow,
                 input flag);
endinterface

// File: include/mdc_pkg.sv
// package of constants and types for the motor drive io control block
package mdc_pkg;

   // ------------------------------------------------------------
   // clock and rotation pulse timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 32'h0000_0032;
   localparam int unsigned PULSE_WIDTH_NS = 32'h0003_0D40;
   localparam int unsigned TIMER_W = 32'h0000_000C;
   localparam logic [TIMER_W-1:0] PULSE_WIDTH_CYC =
      TIMER_W'((PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [TIMER_W-1:0] TIMER_RST = 12'h000;

   // ------------------------------------------------------------
   // rotor feedback scaling
   // ------------------------------------------------------------
   localparam int unsigned PULSES_PER_TURN = 32'h0000_001E;
   localparam int unsigned STEPS_PER_TURN = 32'h0000_003C;
   localparam int unsigned STEP_W = 32'h0000_0004;
   localparam logic [STEP_W-1:0] STEPS_PER_PULSE_M1 =
      STEP_W'(STEPS_PER_TURN / PULSES_PER_TURN - 1);
   localparam logic [STEP_W-1:0] STEP_RST = 4'h0;

   // ------------------------------------------------------------
   // data widths and reset values
   // ------------------------------------------------------------
   localparam int unsigned SPEED_W = 32'h0000_000C;
   localparam int unsigned SEL_W = 32'h0000_0004;
   localparam logic [SEL_W-1:0] OP_DATA_RST = 4'h0;
   localparam logic NARROW_SEL_HI = 1'h0;

   typedef enum logic [1:0] {
      ST_STOPPED,
      ST_RUNNING,
      ST_DECEL,
      ST_HALT
   } mdc_motion_type;

endpackage

// File: tb/mdc_io_control_tb_top.sv
// self-checking testbench for the motor drive io control block
`timescale 1ns/1ps
module mdc_io_control_tb_top;
   logic clk_in = 1'h0, sys_rst_in = 1'h1, three_wire_mode_in = 1'h0;
   logic forward_is_ccw_in = 1'h0, forward_run_in = 1'h0;
   logic reverse_run_in = 1'h0, stop_mode_in = 1'h0, run_gate_in = 1'h0;
   logic hard_run_enable_in = 1'h0, direction_select_in = 1'h0;
   logic speed_select_wide_in = 1'h0, alarm_clear_in = 1'h0;
   logic protect_trip_in = 1'h0, external_fault_stop_in = 1'h1;
   logic brake_motor_in = 1'h0, brake_release_in = 1'h0;
   logic hold_enable_in = 1'h0, hold_release_in = 1'h0;
   logic torque_limit_enable_in = 1'h1, torque_at_limit_in = 1'h0;
   logic notice_event_in = 1'h0, notice_clear_in = 1'h0;
   logic panel_unlock_in = 1'h1;
   logic [3:0] sel = 4'h0;
   logic [mdc_pkg::SPEED_W-1:0] speed_set_in = 12'h000;
   logic [mdc_pkg::SPEED_W-1:0] speed_detect_in = 12'h000;
   logic [mdc_pkg::SPEED_W-1:0] speed_window_in = 12'h000;
   logic motor_rotating_in, rotor_step_in, rotor_step_ccw_in;
   logic run_cmd_out, decel_stop_out, instant_stop_out, dir_ccw_cmd_out;
   logic [mdc_pkg::SEL_W-1:0] op_data_number_out;
   logic brake_release_out, shaft_hold_out, torque_limit_active_out;
   logic panel_locked_out, alarm_active_out, fault_n_out, speed_pulse_out;
   logic motion_active_out, notice_out, torque_limited_flag_out;
   logic speed_reached_out, rotation_ccw_out, prev_pulse = 1'h0;
   int errors = 0, checked = 0, seed = 13, i, d, n;
   int steps = 0, pulses = 0, hi_cyc = 0;
   int exp_q[$];

   mdc_io_control dut (.clk_in, .sys_rst_in, .three_wire_mode_in,
      .forward_is_ccw_in, .forward_run_in, .reverse_run_in, .stop_mode_in,
      .run_gate_in, .hard_run_enable_in, .direction_select_in,
      .speed_select_bit0_in(sel[0]), .speed_select_bit1_in(sel[1]),
      .speed_select_bit2_in(sel[2]), .speed_select_bit3_in(sel[3]),
      .speed_select_wide_in, .alarm_clear_in, .protect_trip_in,
      .external_fault_stop_in, .brake_motor_in, .brake_release_in,
      .hold_enable_in, .hold_release_in, .torque_limit_enable_in,
      .torque_at_limit_in, .notice_event_in, .notice_clear_in,
      .panel_unlock_in, .motor_rotating_in, .rotor_step_in,
      .rotor_step_ccw_in, .speed_set_in, .speed_detect_in, .speed_window_in,
      .run_cmd_out, .decel_stop_out, .instant_stop_out, .dir_ccw_cmd_out,
      .op_data_number_out, .brake_release_out, .shaft_hold_out,
      .torque_limit_active_out, .panel_locked_out, .alarm_active_out,
      .fault_n_out, .speed_pulse_out, .motion_active_out, .notice_out,
      .torque_limited_flag_out, .speed_reached_out, .rotation_ccw_out);

   mdc_plant_model plant (.clk_in, .run_cmd_in(run_cmd_out),
      .dir_ccw_in(dir_ccw_cmd_out), .rotating_out(motor_rotating_in),
      .step_out(rotor_step_in), .step_ccw_out(rotor_step_ccw_in));

   // ------------------------------------------------------------
   // clock, monitors and shared tasks
   // ------------------------------------------------------------
   initial begin
      forever #25 clk_in = ~clk_in;
   end

   always @(negedge clk_in) begin
      if (rotor_step_in === 1'h1) steps++;
      if (speed_pulse_out === 1'h1) hi_cyc++;
      if (speed_pulse_out === 1'h1 && prev_pulse !== 1'h1) pulses++;
      prev_pulse = speed_pulse_out;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("FAIL %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int k);
      repeat (k) @(negedge clk_in);
   endtask

   task automatic do_reset();
      sys_rst_in = 1'h1;
      cyc(6);
      chk(fault_n_out, 1'h1);
      chk(alarm_active_out, 1'h0);
      sys_rst_in = 1'h0;
      cyc(1);
   endtask

   task automatic clear_edge();
      alarm_clear_in = 1'h1;
      cyc(1);
      alarm_clear_in = 1'h0;
      cyc(1);
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial begin
      repeat (90000) @(posedge clk_in);
      errors++;
      end_of_test();
   end

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   initial begin
      do_reset();
      for (i = 0; i < 16; i++) begin
         sel = 4'($random(seed));
         speed_select_wide_in = 1'($random(seed));
         exp_q.push_back(speed_select_wide_in ? sel : sel[1:0]);
         cyc(1);
         chk(op_data_number_out, exp_q.pop_front());
      end
      for (i = 0; i < 8; i++) begin
         forward_is_ccw_in = i[0];
         stop_mode_in = i[1];
         forward_run_in = !i[2];
         reverse_run_in = i[2];
         cyc(1);
         chk(run_cmd_out, 1'h1);
         chk(dir_ccw_cmd_out, i[0] ^ i[2]);
         cyc(4);
         chk(motion_active_out, 1'h1);
         forward_run_in = 1'h0;
         reverse_run_in = 1'h0;
         cyc(1);
         chk({run_cmd_out, decel_stop_out, instant_stop_out},
             {1'h0, !i[1], i[1]});
         cyc(6);
         chk({run_cmd_out, decel_stop_out, motion_active_out}, 0);
      end
      three_wire_mode_in = 1'h1;
      for (i = 0; i < 4; i++) begin
         run_gate_in = 1'h1;
         direction_select_in = i[0];
         cyc(2);
         chk(run_cmd_out, 1'h0);
         hard_run_enable_in = 1'h1;
         cyc(1);
         chk(run_cmd_out, 1'h1);
         chk(dir_ccw_cmd_out, i[0]);
         cyc(4);
         if (i[1]) hard_run_enable_in = 1'h0;
         else run_gate_in = 1'h0;
         cyc(1);
         chk({decel_stop_out, instant_stop_out}, {!i[1], i[1]});
         run_gate_in = 1'h0;
         hard_run_enable_in = 1'h0;
         cyc(6);
      end
      three_wire_mode_in = 1'h0;
      forward_run_in = 1'h1;
      cyc(4);
      protect_trip_in = 1'h1;
      cyc(1);
      protect_trip_in = 1'h0;
      chk({alarm_active_out, fault_n_out}, 2'h2);
      cyc(1);
      chk({run_cmd_out, instant_stop_out}, 2'h1);
      cyc(6);
      clear_edge();
      chk(alarm_active_out, 1'h1);
      forward_run_in = 1'h0;
      cyc(1);
      clear_edge();
      chk({alarm_active_out, fault_n_out}, 2'h1);
      forward_run_in = 1'h1;
      cyc(4);
      external_fault_stop_in = 1'h0;
      cyc(1);
      chk(alarm_active_out, 1'h1);
      cyc(1);
      chk({run_cmd_out, instant_stop_out}, 2'h1);
      forward_run_in = 1'h0;
      external_fault_stop_in = 1'h1;
      cyc(6);
      clear_edge();
      chk(alarm_active_out, 1'h0);
      notice_event_in = 1'h1;
      cyc(1);
      notice_event_in = 1'h0;
      chk(notice_out, 1'h1);
      cyc(2);
      notice_clear_in = 1'h1;
      cyc(1);
      notice_clear_in = 1'h0;
      chk(notice_out, 1'h0);
      for (i = 0; i < 24; i++) begin
         {torque_limit_enable_in, torque_at_limit_in, panel_unlock_in,
          brake_motor_in, brake_release_in, hold_enable_in,
          hold_release_in} = 7'($random(seed));
         speed_set_in = 12'h100 + 12'($random(seed) & 1023);
         speed_detect_in = speed_set_in + 12'($random(seed) & 63) - 12'h020;
         speed_window_in = 12'($random(seed) & 31);
         cyc(1);
         d = int'(speed_detect_in) - int'(speed_set_in);
         if (d < 0) d = -d;
         chk(speed_reached_out, d <= int'(speed_window_in));
         chk(torque_limit_active_out, torque_limit_enable_in);
         chk(panel_locked_out, !panel_unlock_in);
         if (torque_limit_enable_in)
            chk(torque_limited_flag_out, torque_at_limit_in);
         chk(brake_release_out, brake_motor_in & brake_release_in);
         chk(shaft_hold_out, hold_enable_in & !hold_release_in
             & !(brake_motor_in & brake_release_in));
      end
      {torque_limit_enable_in, panel_unlock_in} = 2'h3;
      do_reset();
      forward_is_ccw_in = 1'h1;
      {steps, pulses, hi_cyc} = '0;
      forward_run_in = 1'h1;
      for (n = 0; n < 50000 && steps < 20; n++) cyc(1);
      forward_run_in = 1'h0;
      cyc(4100);
      chk(pulses, 10);
      chk(hi_cyc, 10 * int'(mdc_pkg::PULSE_WIDTH_CYC));
      chk(rotation_ccw_out, 1'h1);
      end_of_test();
   end
endmodule // mdc_io_control_tb_top

// File: tb/mdc_plant_model.sv
// far-side model: motor and power stage giving rotation feedback
`timescale 1ns/1ps
module mdc_plant_model #(
   parameter int STEP_GAP = 2100
) (
   input wire logic clk_in,
   input wire logic run_cmd_in,
   input wire logic dir_ccw_in,
   output logic rotating_out = 1'h0,
   output logic step_out = 1'h0,
   output logic step_ccw_out = 1'h0
);
   int lag_cnt = 0;
   int gap_cnt = 0;
   // spins up one cycle after a run command, coasts three after it ends
   always @(posedge clk_in) begin
      lag_cnt <= run_cmd_in ? 0 : lag_cnt + 1;
      rotating_out <= run_cmd_in | (rotating_out & (lag_cnt < 3));
      gap_cnt <= (rotating_out && gap_cnt < STEP_GAP) ? gap_cnt + 1 : 0;
      step_out <= rotating_out && (gap_cnt == STEP_GAP);
      // direction only valid with a step, scrambled otherwise
      step_ccw_out <= (rotating_out && gap_cnt == STEP_GAP) ? dir_ccw_in
                      : ~step_ccw_out;
   end
endmodule // mdc_plant_model
